/* File: src/tpp_timer.sv */
// Purpose: Output flip-flop control, prescaler, edge select and counter.
// Assumes: Pins and sub clock ticks are synchronous to clk_in.
// Notes: Reads return data one cycle after the read strobe.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module tpp_timer
  import tpp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic sub_tick_in,
  input wire logic sub_x4_tick_in,
  input wire logic timer_input_a_in,
  input wire logic timer_input_b_in,
  output logic timer_output_pin_out,
  output logic pin0_oe_out,
  output logic [7:0] port3_direction_out,
  output logic first_match_irq_out,
  output logic second_match_irq_out
);
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev,
                                    input logic cur);
    case (sel)
      EDGE_FALL: edge_hit = prev & ~cur;
      EDGE_RISE: edge_hit = ~prev & cur;
      EDGE_BOTH: edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  logic [7:0] port3_direction_q;
  logic [7:0] timer_prescale_edge_select_q;
  logic [7:0] timer_output_control_q;
  logic [7:0] mode_q;
  logic [7:0] cap_ctrl_q;
  logic [15:0] cmp1_q, cmp2_q, count_q;
  logic [15:0] cmp1_d, cmp2_d, count_d;
  logic output_flip_flop_q, output_flip_flop_d;
  logic half_q, seen_q;
  logic [1:0] samp_a_q, samp_b_q;
  logic lvl_a_q, lvl_b_q, prev_a_q, prev_b_q;
  logic [7:0] rdata_q;
  logic out_q, oe_q, irq1_q, irq2_q;

  wire wr_dir = wr_in && addr_in == OFS_PORT3_DIR;
  wire wr_mode = wr_in && addr_in == OFS_MODE_CTRL;
  wire wr_ps = wr_in && addr_in == OFS_PRESCALE;
  wire wr_cc = wr_in && addr_in == OFS_CAP_CTRL;
  wire wr_oc = wr_in && addr_in == OFS_OUT_CTRL;
  wire wr_c1l = wr_in && addr_in == OFS_CMP1_LO;
  wire wr_c1h = wr_in && addr_in == OFS_CMP1_HI;
  wire wr_c2l = wr_in && addr_in == OFS_CMP2_LO;
  wire wr_c2h = wr_in && addr_in == OFS_CMP2_HI;

  wire tpp_mode_t mode = tpp_mode_t'(mode_q[MC_MODE_LSB +: 2]);
  wire tpp_clk_t clk_sel =
    tpp_clk_t'(timer_prescale_edge_select_q[PS_CLK_LSB +: 2]);
  wire [1:0] sel_a = timer_prescale_edge_select_q[PS_EDGE_A_LSB +: 2];
  wire [1:0] sel_b = timer_prescale_edge_select_q[PS_EDGE_B_LSB +: 2];
  wire running = mode != TPP_MODE_STOP;
  wire detect = running || seen_q;

  wire edge_a = running && edge_hit(sel_a, prev_a_q, lvl_a_q);
  wire edge_b = running && edge_hit(sel_b, prev_b_q, lvl_b_q);
  // Inverting the first input's selection drops both-edge to none.
  wire edge_a_inv = running &&
    edge_hit({sel_a[1], ~sel_a[0]}, prev_a_q, lvl_a_q);

  logic tick;
  always_comb begin
    case (clk_sel)
      TPP_CLK_SUB: tick = sub_tick_in;
      TPP_CLK_HALF: tick = sub_tick_in & half_q;
      TPP_CLK_X4: tick = sub_x4_tick_in;
      TPP_CLK_EDGE_A: tick = edge_a;
      default: tick = 1'b0;
    endcase
  end
  wire count_tick = running && tick;

  wire first_cap = cap_ctrl_q[CC_FIRST_CAP];
  wire second_cap = cap_ctrl_q[CC_SECOND_CAP];
  wire first_trig = cap_ctrl_q[CC_FIRST_TRIG_A] ? edge_a_inv : edge_b;
  wire cap1 = first_cap && first_trig;
  wire cap2 = second_cap && edge_a;
  wire match1 = count_tick && !first_cap && count_q == cmp1_q;
  wire match2 = count_tick && !second_cap && count_q == cmp2_q;
  wire toggle_mode = mode == TPP_MODE_FREE || mode == TPP_MODE_CLR_MATCH;
  wire oc_set = wdata_in[OC_SET];
  wire oc_clr = wdata_in[OC_CLEAR];
  wire wrap = count_tick && count_q == CNT_MAX;

  always_comb begin
    count_d = count_q;
    case (mode)
      TPP_MODE_STOP: count_d = CNT_ZERO;
      TPP_MODE_FREE: begin
        if (count_tick) count_d = count_q + CNT_ONE;
      end
      TPP_MODE_CLR_EDGE: begin
        if (edge_a) count_d = CNT_ZERO;
        else if (count_tick) count_d = count_q + CNT_ONE;
      end
      TPP_MODE_CLR_MATCH: begin
        if (count_tick && count_q == cmp1_q) count_d = CNT_ZERO;
        else if (count_tick) count_d = count_q + CNT_ONE;
      end
      default: count_d = CNT_ZERO;
    endcase
  end

  // Hardware capture wins over a software write in the same cycle.
  always_comb begin
    cmp1_d = cmp1_q;
    if (wr_c1l) cmp1_d[7:0] = wdata_in;
    if (wr_c1h) cmp1_d[15:8] = wdata_in;
    if (cap1) cmp1_d = count_q;
    cmp2_d = cmp2_q;
    if (wr_c2l) cmp2_d[7:0] = wdata_in;
    if (wr_c2h) cmp2_d[15:8] = wdata_in;
    if (cap2) cmp2_d = count_q;
  end

  // Direct set and clear take priority over match inversion.
  always_comb begin
    output_flip_flop_d = output_flip_flop_q;
    if (wr_oc && oc_set && !oc_clr) output_flip_flop_d = 1'b1;
    else if (wr_oc && oc_clr && !oc_set) output_flip_flop_d = 1'b0;
    else if (toggle_mode)
      output_flip_flop_d = output_flip_flop_q ^
        (match1 & timer_output_control_q[OC_INV_FIRST]) ^
        (match2 & timer_output_control_q[OC_INV_SECOND]);
  end

  logic [7:0] rd_mux;
  always_comb begin
    case (addr_in)
      OFS_PORT3_DIR: rd_mux = port3_direction_q | PORT3_FIXED;
      OFS_MODE_CTRL: rd_mux = mode_q;
      OFS_PRESCALE: rd_mux = timer_prescale_edge_select_q;
      OFS_CAP_CTRL: rd_mux = cap_ctrl_q;
      // Only stored bits return; set and clear read as zero.
      OFS_OUT_CTRL: rd_mux = timer_output_control_q & OC_STORED_MASK;
      OFS_CMP1_LO: rd_mux = cmp1_q[7:0];
      OFS_CMP1_HI: rd_mux = cmp1_q[15:8];
      OFS_CMP2_LO: rd_mux = cmp2_q[7:0];
      OFS_CMP2_HI: rd_mux = cmp2_q[15:8];
      OFS_COUNT_LO: rd_mux = count_q[7:0];
      OFS_COUNT_HI: rd_mux = count_q[15:8];
      default: rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      port3_direction_q <= RST_PORT3_DIR;
      timer_prescale_edge_select_q <= RST_ZERO;
      timer_output_control_q <= RST_ZERO;
      cap_ctrl_q <= RST_ZERO;
    end else begin
      if (wr_dir) port3_direction_q <= wdata_in | PORT3_FIXED;
      if (wr_ps) timer_prescale_edge_select_q <= wdata_in & PS_MASK;
      if (wr_cc) cap_ctrl_q <= wdata_in & CC_MASK;
      if (wr_oc) timer_output_control_q <= wdata_in & OC_STORED_MASK;
    end
  end

  // Overflow: a wrap in the cycle of a clearing write still sets it.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) mode_q <= RST_ZERO;
    else if (wr_mode) mode_q <= (wdata_in & MC_MASK) | {7'h00, wrap};
    else if (wrap) mode_q[MC_OVF] <= 1'b1;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cmp1_q <= CNT_ZERO;
      cmp2_q <= CNT_ZERO;
      count_q <= CNT_ZERO;
      output_flip_flop_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      cmp1_q <= cmp1_d;
      cmp2_q <= cmp2_d;
      count_q <= count_d;
      output_flip_flop_q <= output_flip_flop_d;
      if (sub_tick_in) half_q <= ~half_q;
    end
  end

  // A level is accepted after two equal main clock samples.
  // Previous level starts low and only tracks once counting began.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      samp_a_q <= 2'b00;
      samp_b_q <= 2'b00;
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      samp_a_q <= {samp_a_q[0], timer_input_a_in};
      samp_b_q <= {samp_b_q[0], timer_input_b_in};
      if (samp_a_q[0] == samp_a_q[1]) lvl_a_q <= samp_a_q[0];
      if (samp_b_q[0] == samp_b_q[1]) lvl_b_q <= samp_b_q[0];
      if (detect) prev_a_q <= lvl_a_q;
      if (detect) prev_b_q <= lvl_b_q;
      if (running) seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= RST_ZERO;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else begin
      rdata_q <= rd_in ? rd_mux : RST_ZERO;
      // Output gated by the enable bit.
      out_q <= output_flip_flop_q & timer_output_control_q[OC_ENABLE];
      oe_q <= ~port3_direction_q[0];
      // Interrupt on first match or second-input capture.
      irq1_q <= match1 || (cap1 && !cap_ctrl_q[CC_FIRST_TRIG_A]);
      irq2_q <= match2 || cap2;
    end
  end

  assign rdata_out = rdata_q;
  assign timer_output_pin_out = out_q;
  assign pin0_oe_out = oe_q;
  assign port3_direction_out = port3_direction_q;
  assign first_match_irq_out = irq1_q;
  assign second_match_irq_out = irq2_q;

  chk_no_both_capture: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (sel_a == EDGE_BOTH && cap_ctrl_q[CC_FIRST_TRIG_A]) |-> !cap1)
    else $error("first register captured on a both-edge input");

  chk_second_invert: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (match2 && !match1 && !wr_oc && toggle_mode &&
     timer_output_control_q[OC_INV_SECOND]) |=>
    output_flip_flop_q != $past(output_flip_flop_q))
    else $error("flip-flop did not invert on second match");

  chk_direct_set: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (wr_oc && wdata_in[OC_SET] && !wdata_in[OC_CLEAR]) |=>
    output_flip_flop_q ##1
    timer_output_pin_out == $past(timer_output_control_q[OC_ENABLE]))
    else $error("direct set failed");

  chk_setclr_read: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (rd_in && addr_in == OFS_OUT_CTRL) |=>
    rdata_out[OC_SET] == 1'b0 && rdata_out[OC_CLEAR] == 1'b0)
    else $error("set or clear bit read back as one");

  chk_first_invert: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (match1 && !match2 && !wr_oc && toggle_mode &&
     !timer_output_control_q[OC_INV_FIRST]) |=>
    $stable(output_flip_flop_q))
    else $error("flip-flop inverted with first inversion off");

  chk_output_gate: assert property (
    @(posedge clk_in) disable iff (reset_in)
    !timer_output_control_q[OC_ENABLE] |=> !timer_output_pin_out)
    else $error("timer output high while disabled");

  chk_interval_clear: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (mode == TPP_MODE_CLR_MATCH && match1 && !wr_mode) |=>
    count_q == CNT_ZERO ##0 first_match_irq_out)
    else $error("interval match did not clear and interrupt");

  chk_free_wrap: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (mode == TPP_MODE_FREE && wrap && !wr_mode) |=>
    count_q == CNT_ZERO && mode_q[MC_OVF])
    else $error("free-run wrap missing");

  chk_stop_clears: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (mode == TPP_MODE_STOP) |=> count_q == CNT_ZERO)
    else $error("stopped counter not cleared");
endmodule
`default_nettype wire

/* File: src/tpp_pkg.sv */
// Purpose: Constants for the 16-bit timer output, prescale and pulse block.
// Assumes: 8-bit register port, one clock, sub clock ticks as inputs.
// Notes: Rules follow, one to a line.
// Operation
// - Both-edge first input selection disables first register capture on it.
// - Bit 4 set: output flip-flop inverts on second register match; the code inverts only in modes 01 and 11, not in mode 10.
// - Direct set sets, direct clear clears, neither holds; both is prohibited.
// - Direct set and clear bits always read back as zero.
// - Bit 1 set: output flip-flop inverts on first register match; the code inverts only in modes 01 and 11, not in mode 10.
// - Enable bit passes flip-flop to output pin, else output is low.
// - Prescale bits 7:6 pick second input edge: fall, rise, both.
// - Prescale bits 5:4 pick first input edge: fall, rise, both.
// - Prescale bits 1:0 pick sub clock, half, times four, first input edges.
// - External count pulses exceed two main clocks; sampled by main clock.
// - High pin after reset yields one rising edge at first enable only.
// - Interval mode clears counter on first match and raises first interrupt.
// - Pulse period is first value plus one, width second value plus one.
// - Mode 11 clears on first match; mode 01 runs free and wraps.
package tpp_pkg;
  localparam logic [15:0] OFS_PORT3_DIR = 16'hff23;
  localparam logic [15:0] OFS_MODE_CTRL = 16'hff66;
  localparam logic [15:0] OFS_PRESCALE = 16'hff67;
  localparam logic [15:0] OFS_CAP_CTRL = 16'hff68;
  localparam logic [15:0] OFS_OUT_CTRL = 16'hff69;
  localparam logic [15:0] OFS_CMP1_LO = 16'hff60;
  localparam logic [15:0] OFS_CMP1_HI = 16'hff61;
  localparam logic [15:0] OFS_CMP2_LO = 16'hff62;
  localparam logic [15:0] OFS_CMP2_HI = 16'hff63;
  localparam logic [15:0] OFS_COUNT_LO = 16'hff64;
  localparam logic [15:0] OFS_COUNT_HI = 16'hff65;
  localparam logic [7:0] RST_PORT3_DIR = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] PORT3_FIXED = 8'hf0;
  // Output control fields.
  localparam int OC_ENABLE = 0;
  localparam int OC_INV_FIRST = 1;
  localparam int OC_CLEAR = 2;
  localparam int OC_SET = 3;
  localparam int OC_INV_SECOND = 4;
  localparam logic [7:0] OC_STORED_MASK = 8'h13;
  // Mode control fields.
  localparam int MC_OVF = 0;
  localparam int MC_MODE_LSB = 2;
  localparam logic [7:0] MC_MASK = 8'h0d;
  // Capture control fields.
  localparam int CC_FIRST_CAP = 0;
  localparam int CC_FIRST_TRIG_A = 1;
  localparam int CC_SECOND_CAP = 2;
  localparam logic [7:0] CC_MASK = 8'h07;
  // Prescale fields.
  localparam int PS_CLK_LSB = 0;
  localparam int PS_EDGE_A_LSB = 4;
  localparam int PS_EDGE_B_LSB = 6;
  localparam logic [7:0] PS_MASK = 8'hf3;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  typedef enum logic [1:0] {
    TPP_MODE_STOP = 2'b00,
    TPP_MODE_FREE = 2'b01,
    TPP_MODE_CLR_EDGE = 2'b10,
    TPP_MODE_CLR_MATCH = 2'b11
  } tpp_mode_t;
  typedef enum logic [1:0] {
    TPP_CLK_SUB = 2'b00,
    TPP_CLK_HALF = 2'b01,
    TPP_CLK_X4 = 2'b10,
    TPP_CLK_EDGE_A = 2'b11
  } tpp_clk_t;
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
endpackage

/* File: test/tpp_partner.sv */
// Purpose: Far-side model: sub clock ticks and pulse sources on timer pins.
// Assumes: Ticks are one main clock wide; pins change after clock edges.
// Notes: Sub ticks every 32 clocks, times-four ticks every 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module tpp_partner (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic a_run_in,
  output logic sub_tick_out,
  output logic sub_x4_tick_out,
  output logic pin_a_out,
  output logic pin_b_out
);
  logic [4:0] div_q;
  logic [4:0] wid_q;
  logic pin_a_q;
  logic pin_b_q;
  assign sub_tick_out = (div_q == 5'h00);
  // No halt: times-four ticks never stop.
  assign sub_x4_tick_out = (div_q[2:0] == 3'h0);
  assign pin_a_out = pin_a_q;
  assign pin_b_out = pin_b_q;
  // Pin A levels hold 20 clocks.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 5'h00;
      wid_q <= 5'h00;
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else begin
      div_q <= div_q + 5'h01;
      if (sub_tick_out) begin
        pin_b_q <= ~pin_b_q;
      end
      if (!a_run_in) begin
        wid_q <= 5'h00;
      end else if (wid_q == 5'h13) begin
        wid_q <= 5'h00;
        pin_a_q <= ~pin_a_q;
      end else begin
        wid_q <= wid_q + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench for the timer output and prescale block.
// Assumes: Partner tick and pin periods are fixed and known here.
// Notes: Intervals are measured in clocks between design events.
`timescale 1ns/1ps
`default_nettype none
module tb
  import tpp_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic a_run = 1'b0;
  logic [7:0] rdata_out;
  logic [7:0] rv;
  logic sub_tick, x4_tick, pin_a, pin_b, pin_out, oe, irq1, irq2;
  logic [7:0] dir;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_ps[6] = '{8'h00, 8'h01, 8'h02, 8'h13, 8'h33, 8'h03};
  int t_per[6] = '{32, 64, 8, 40, 20, 40};
  logic [8:0] dsc[6] = '{9'h013, 9'h003, 9'h00a, 9'h010, 9'h003, 9'h008};
  always #2 clk_in = ~clk_in;
  tpp_timer i_tpp_timer (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sub_tick_in(sub_tick), .sub_x4_tick_in(x4_tick),
    .timer_input_a_in(pin_a), .timer_input_b_in(pin_b),
    .timer_output_pin_out(pin_out), .pin0_oe_out(oe),
    .port3_direction_out(dir), .first_match_irq_out(irq1),
    .second_match_irq_out(irq2));
  tpp_partner i_tpp_partner (.clk_in(clk_in), .reset_in(reset_in),
    .a_run_in(a_run), .sub_tick_out(sub_tick), .sub_x4_tick_out(x4_tick),
    .pin_a_out(pin_a), .pin_b_out(pin_b));
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk_val(input string w, input logic [7:0] e,
                         input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_int(input string w, input int e, input int g);
    tests_run++;
    if (g != e) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Span of k + 1 count clocks of per main clocks each.
  function automatic int span(input int k, input int per);
    return (k + 1) * per;
  endfunction
  task automatic set_cmp(input int n, input int m);
    bus_wr(OFS_CMP1_LO, n[7:0]);
    bus_wr(OFS_CMP1_HI, 8'h00);
    bus_wr(OFS_CMP2_LO, m[7:0]);
    bus_wr(OFS_CMP2_HI, 8'h00);
  endtask
  // Waits for the pin (sel 0), first irq (1) or second irq (2) to be v.
  task automatic wait_ev(input int sel, input logic v, output int t);
    int k;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk_in);
      #1;
      if (((sel == 2) ? irq2 : (sel == 1) ? irq1 : pin_out) === v) begin
        break;
      end
    end
    if (k == 2000) begin
      errors++;
      $display("BAD wait expected %0d seen none", v);
    end
    t = cyc;
  endtask
  initial begin
    int n, m, t0, t1, t2, p;
    logic [7:0] ps;
    logic ext;
    void'($urandom(32'hd05e));
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    bus_rd(OFS_PORT3_DIR, rv);
    chk_val("port3 reset", RST_PORT3_DIR, rv);
    chk_val("port3 out", RST_PORT3_DIR, dir);
    bus_rd(OFS_PRESCALE, rv);
    chk_val("prescale reset", RST_ZERO, rv);
    bus_rd(OFS_OUT_CTRL, rv);
    chk_val("outctl reset", RST_ZERO, rv);
    bus_rd(16'hff70, rv);
    chk_val("unmapped", 8'h00, rv);
    bus_wr(OFS_PORT3_DIR, 8'h00);
    bus_rd(OFS_PORT3_DIR, rv);
    chk_val("port3 rw", PORT3_FIXED, rv);
    chk_val("port3 out rw", PORT3_FIXED, dir);
    chk_val("pin0 oe", 8'h01, {7'h00, oe});
    bus_wr(OFS_OUT_CTRL, 8'h1b);
    bus_rd(OFS_OUT_CTRL, rv);
    chk_val("outctl read", 8'h13, rv);
    foreach (dsc[i]) begin
      bus_wr(OFS_OUT_CTRL, dsc[i][8:1]);
      repeat (4) @(posedge clk_in);
      #1;
      chk_val("set pin", {7'h00, dsc[i][0]}, {7'h00, pin_out});
    end
    $display("test registers done");
    foreach (t_ps[i]) begin
      n = 2 + ($urandom % 5);
      bus_wr(OFS_MODE_CTRL, 8'h00);
      ps = t_ps[i][7:0];
      ps[7:6] = 2'($urandom % 3);
      if (ps[7:6] == 2'b10) begin
        ps[7:6] = 2'b11;
      end
      bus_wr(OFS_PRESCALE, ps);
      bus_rd(OFS_PRESCALE, rv);
      chk_val("prescale rw", ps, rv);
      set_cmp(n, 1);
      ext = (ps[1:0] == 2'b11);
      bus_wr(OFS_PORT3_DIR, ext ? 8'h01 : 8'h00);
      bus_wr(OFS_OUT_CTRL, ext ? 8'h00 : 8'h03);
      a_run <= ext;
      bus_wr(OFS_MODE_CTRL, 8'h0c);
      wait_ev(1, 1'b1, t0);
      wait_ev(1, 1'b1, t1);
      bus_rd(OFS_COUNT_LO, rv);
      chk_val("count cleared", 8'h00, rv);
      chk_int("irq spacing", span(n, t_per[i]), t1 - t0);
      wait_ev(2, 1'b1, t2);
      chk_int("second match", span(1, t_per[i]), t2 - t1);
      if (!ext) begin
        wait_ev(0, ~pin_out, t0);
        wait_ev(0, ~pin_out, t1);
        chk_int("toggle gap", span(n, t_per[i]), t1 - t0);
      end
      a_run <= 1'b0;
    end
    $display("test interval done");
    bus_wr(OFS_MODE_CTRL, 8'h00);
    set_cmp(32'h5a, 0);
    bus_wr(OFS_PORT3_DIR, 8'h03);
    bus_wr(OFS_OUT_CTRL, 8'h00);
    bus_wr(OFS_PRESCALE, 8'h72);
    bus_wr(OFS_CAP_CTRL, 8'h03);
    a_run <= 1'b1;
    bus_wr(OFS_MODE_CTRL, 8'h04);
    repeat (100) @(posedge clk_in);
    bus_rd(OFS_CMP1_LO, rv);
    chk_val("both-edge capture", 8'h5a, rv);
    bus_wr(OFS_MODE_CTRL, 8'h00);
    ps = ($urandom % 2) ? 8'hc2 : 8'h42;
    bus_wr(OFS_PRESCALE, ps);
    bus_wr(OFS_CAP_CTRL, 8'h01);
    bus_wr(OFS_MODE_CTRL, 8'h04);
    wait_ev(1, 1'b1, t0);
    wait_ev(1, 1'b1, t1);
    chk_int("b edge gap", ps[7] ? 32 : 64, t1 - t0);
    bus_wr(OFS_MODE_CTRL, 8'h00);
    bus_wr(OFS_CAP_CTRL, 8'h00);
    a_run <= 1'b0;
    $display("test capture done");
    bus_wr(OFS_MODE_CTRL, 8'h00);
    // Keep 0 < m < n.
    n = 3 + ($urandom % 4);
    m = 1 + ($urandom % (n - 1));
    bus_wr(OFS_PORT3_DIR, 8'h00);
    bus_wr(OFS_PRESCALE, 8'h00);
    set_cmp(n, m);
    bus_wr(OFS_OUT_CTRL, 8'h17);
    bus_wr(OFS_MODE_CTRL, 8'h0c);
    wait_ev(0, 1'b0, t0);
    wait_ev(0, 1'b1, t0);
    wait_ev(0, 1'b0, t1);
    wait_ev(0, 1'b1, t2);
    chk_int("pulse period", span(n, 32), t2 - t0);
    p = t1 - t0;
    if (p != span(m, 32)) begin
      p = t2 - t1;
    end
    chk_int("pulse width", span(m, 32), p);
    $display("test pulse done");
    end_of_test();
  end
endmodule
`default_nettype wire
